// ==== hdl/dlo_top.sv ====
// Data-link overhead access: code detector, FDL buffers, E1 Sa/Si capture
`timescale 1ns/1ps
`default_nettype none
module dlo_top #(
  parameter int FRAMER = 1
) (
  input  wire logic                    CLK,
  input  wire logic                    NRST,
  input  wire logic [dlo_pkg::AW-1:0]  ADDR,
  input  wire logic [dlo_pkg::DW-1:0]  WR_DATA,
  input  wire logic                    WR,
  input  wire logic                    RD,
  output logic      [dlo_pkg::DW-1:0]  RD_DATA,
  output logic                         INT_N,
  input  wire logic                    T1_MODE,
  input  wire logic                    ESF_MODE,
  input  wire logic                    RX_DL_STB,
  input  wire logic                    RX_DL_BIT,
  input  wire logic                    RX_MF_STB,
  input  wire logic                    TX_DL_REQ,
  output logic                         TX_DL_BIT,
  output logic                         TX_DL_EN,
  input  wire logic                    E1_AF_STB,
  input  wire logic [dlo_pkg::DW-1:0]  E1_AF_IN,
  input  wire logic [dlo_pkg::DW-1:0]  E1_NAF_IN,
  input  wire logic                    E1_MF_STB,
  input  wire logic [7*dlo_pkg::DW-1:0] E1_MF_IN
);
  import dlo_pkg::*;

  typedef struct packed {
    logic [7:0]      ctl;
    logic [7:0]      rxdl;
    logic [7:0]      rxsh;
    logic [3:0]      rxcnt;
    logic [7:0]      raf;
    logic [7:0]      rnaf;
    logic [6:0][7:0] e1mf;
    logic [1:0]      rx_latched_status_two;
    logic [2:0]      rx_latched_status_seven;
    logic [7:0]      rim2;
    logic [7:0]      rx_interrupt_mask_seven;
    logic [9:0][7:0] e1tx;
    logic [7:0]      txdl;
    logic [7:0]      tcr2;
    logic            tx_latched_status_two;
    logic [7:0]      tx_interrupt_mask_two;
    logic [7:0]      txsh;
    logic [3:0]      txcnt;
    dlo_tx_st_t      txst;
    logic            txbit;
    logic            txen;
    logic [7:0]      rdata;
    logic            int_n;
  } dlo_st_t;

  dlo_st_t s;
  dlo_st_t next_s;

  logic       hit;
  logic [8:0] loc;
  logic       esf;
  logic       d4;
  logic       src_buf;
  logic [3:0] tx_len;
  logic [3:0] ti;

  dlo_boc_if bi ();

  // Transmit E1 register slot, 4'hF when the offset is none of them
  function automatic logic [3:0] tx_idx(input logic [8:0] a);
    case (a)
      OFF_TSA_CTL: tx_idx = 4'h0;
      OFF_TAF:     tx_idx = 4'h1;
      OFF_TNAF:    tx_idx = 4'h2;
      OFF_TSI_AF:  tx_idx = 4'h3;
      OFF_TSI_NAF: tx_idx = 4'h4;
      OFF_TSA4:    tx_idx = 4'h5;
      OFF_TSA5:    tx_idx = 4'h6;
      OFF_TSA6:    tx_idx = 4'h7;
      OFF_TSA7:    tx_idx = 4'h8;
      OFF_TSA8:    tx_idx = 4'h9;
      default:     tx_idx = 4'hF;
    endcase
  endfunction : tx_idx

  // Framer window decode
  assign hit = (ADDR[11:9] == 3'(FRAMER - 1));
  assign loc = ADDR[8:0];
  assign ti  = tx_idx(loc);

  // Framing mode decode
  assign esf     = T1_MODE && ESF_MODE;
  assign d4      = T1_MODE && !ESF_MODE;
  assign src_buf = T1_MODE && !s.tcr2[B_SRC];
  // D4 stops after six bits so the top two are never sent
  assign tx_len  = d4 ? DL_BITS_D4 : DL_BITS_ESF;

  // Detector hookup; it sees only ESF data link bits
  assign bi.en   = esf;
  assign bi.stb  = RX_DL_STB;
  assign bi.dbit = RX_DL_BIT;
  assign bi.filt = s.ctl[FILT_LSB +: 2];
  assign bi.dis  = s.ctl[DIS_LSB +: 2];

  dlo_boc u_boc (
    .clk  (CLK),
    .nrst (NRST),
    .b    (bi)
  );

  // Whole next state: host writes first, then hardware sets win
  always_comb begin
    next_s       = s;
    next_s.rdata = RST_REG;

    // Host writes; latched flags clear only where a one is written
    if (WR && hit) begin
      case (loc)
        OFF_BOC_CTL: next_s.ctl  = WR_DATA;
        OFF_RIM2:    next_s.rim2 = WR_DATA;
        OFF_RX_INTERRUPT_MASK_SEVEN:    next_s.rx_interrupt_mask_seven = WR_DATA;
        OFF_TX_INTERRUPT_MASK_TWO:    next_s.tx_interrupt_mask_two = WR_DATA;
        OFF_TX_DL:   next_s.txdl = WR_DATA;
        OFF_TCR2:    next_s.tcr2 = WR_DATA;
        OFF_RX_LATCHED_STATUS_TWO:    next_s.rx_latched_status_two = s.rx_latched_status_two & ~WR_DATA[1:0];
        OFF_RX_LATCHED_STATUS_SEVEN:    next_s.rx_latched_status_seven = s.rx_latched_status_seven & ~WR_DATA[2:0];
        OFF_TX_LATCHED_STATUS_TWO:    next_s.tx_latched_status_two = s.tx_latched_status_two & ~WR_DATA[B_TXEMPTY];
        default: begin
          if (ti != 4'hF) begin
            next_s.e1tx[ti] = WR_DATA;
          end
        end
      endcase
    end

    // Host reads, answered in the next cycle only
    if (RD && hit) begin
      case (loc)
        OFF_BOC_CTL: next_s.rdata = s.ctl;
        OFF_RX_DL:   next_s.rdata = s.rxdl;
        OFF_CODE:    next_s.rdata = {2'h0, bi.code};
        OFF_RAF:     next_s.rdata = s.raf;
        OFF_RNAF:    next_s.rdata = s.rnaf;
        OFF_SI_AF:   next_s.rdata = s.e1mf[0];
        OFF_SI_NAF:  next_s.rdata = s.e1mf[1];
        OFF_SA4:     next_s.rdata = s.e1mf[2];
        OFF_SA5:     next_s.rdata = s.e1mf[3];
        OFF_SA6:     next_s.rdata = s.e1mf[4];
        OFF_SA7:     next_s.rdata = s.e1mf[5];
        OFF_SA8:     next_s.rdata = s.e1mf[6];
        OFF_RX_LATCHED_STATUS_TWO:    next_s.rdata = {6'h00, s.rx_latched_status_two};
        OFF_RX_LATCHED_STATUS_SEVEN:    next_s.rdata = {5'h00, s.rx_latched_status_seven};
        OFF_RIM2:    next_s.rdata = s.rim2;
        OFF_RX_INTERRUPT_MASK_SEVEN:    next_s.rdata = s.rx_interrupt_mask_seven;
        OFF_TX_DL:   next_s.rdata = s.txdl;
        OFF_TCR2:    next_s.rdata = s.tcr2;
        OFF_TX_LATCHED_STATUS_TWO:    next_s.rdata = {3'h0, s.tx_latched_status_two, 4'h0};
        OFF_TX_INTERRUPT_MASK_TWO:    next_s.rdata = s.tx_interrupt_mask_two;
        default: begin
          if (ti != 4'hF) begin
            next_s.rdata = s.e1tx[ti];
          end
        end
      endcase
    end

    // Code detector events
    if (bi.det) begin
      next_s.rx_latched_status_seven[B_DET] = 1'b1;
    end
    if (bi.clr) begin
      next_s.rx_latched_status_seven[B_CLR] = 1'b1;
    end

    // Receive data link buffer; no destuffing, old byte overwritten
    if (T1_MODE && RX_DL_STB) begin
      next_s.rxsh  = {RX_DL_BIT, s.rxsh[7:1]};
      next_s.rxcnt = (s.rxcnt == 4'hF) ? s.rxcnt : s.rxcnt + 4'h1;
      if (esf && s.rxcnt == DL_BITS_ESF - 4'h1) begin
        next_s.rxdl  = next_s.rxsh;
        next_s.rxcnt = RST_CNT;
        next_s.rx_latched_status_seven[B_RXFULL] = 1'b1;
      end
    end
    // D4 keeps the six Fs bits of one multiframe, first one in bit 0
    if (d4 && RX_MF_STB) begin
      next_s.rxdl  = {2'h0, next_s.rxsh[7:2]};
      next_s.rxcnt = RST_CNT;
      next_s.rx_latched_status_seven[B_RXFULL] = 1'b1;
    end

    // E1 double-frame capture
    if (!T1_MODE && E1_AF_STB) begin
      next_s.raf        = E1_AF_IN;
      next_s.rnaf       = E1_NAF_IN;
      next_s.rx_latched_status_two[B_AF] = 1'b1;
    end
    // E1 CRC-4 multiframe capture, all seven bytes together
    if (!T1_MODE && E1_MF_STB) begin
      next_s.e1mf       = E1_MF_IN;
      next_s.rx_latched_status_two[B_MF] = 1'b1;
    end

    // Transmit serializer; plain bits, no zero stuffing inserted
    unique case (s.txst)
      TX_IDLE: begin
        next_s.txen = 1'b0;
        if (src_buf) begin
          next_s.txsh  = s.txdl;
          next_s.txcnt = RST_CNT;
          next_s.txst  = TX_SEND;
        end
      end
      TX_SEND: begin
        next_s.txen = 1'b1;
        if (!src_buf) begin
          next_s.txst = TX_IDLE;
          next_s.txen = 1'b0;
        end else if (TX_DL_REQ) begin
          next_s.txbit = s.txsh[0];
          next_s.txsh  = {1'b0, s.txsh[7:1]};
          next_s.txcnt = s.txcnt + 4'h1;
          if (s.txcnt == tx_len - 4'h1) begin
            // Reload takes whatever the host left, old or new
            next_s.txsh  = s.txdl;
            next_s.txcnt = RST_CNT;
            next_s.tx_latched_status_two  = 1'b1;
          end
        end
      end
    endcase

    // Interrupt from pending unmasked flags of this framer
    next_s.int_n = !(|(next_s.rx_latched_status_seven & s.rx_interrupt_mask_seven[2:0]) ||
                     |(next_s.rx_latched_status_two & s.rim2[1:0]) ||
                     (next_s.tx_latched_status_two && s.tx_interrupt_mask_two[B_TXEMPTY]));
  end

  // State register, one process for all framer state outside the code detector
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      s       <= '0;
      s.txst  <= TX_IDLE;
      s.int_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign RD_DATA   = s.rdata;
  assign INT_N     = s.int_n;
  assign TX_DL_BIT = s.txbit;
  assign TX_DL_EN  = s.txen;

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_int_det_low: assert property (
    s.rx_latched_status_seven[B_DET] && s.rx_interrupt_mask_seven[B_DET] && !WR |=> !INT_N)
    else $error("unmasked detect flag left interrupt high");

  a_int_release: assert property (
    s.rx_latched_status_seven == 3'h0 && s.rx_latched_status_two == 2'h0 && !s.tx_latched_status_two && !bi.det &&
    !bi.clr && !RX_DL_STB && !RX_MF_STB && !E1_AF_STB &&
    !E1_MF_STB && !TX_DL_REQ |=> INT_N)
    else $error("interrupt low with no pending flag");

  a_w1c_zero: assert property (
    WR && hit && loc == OFF_RX_LATCHED_STATUS_SEVEN && WR_DATA[2:0] == 3'h0
    |=> (s.rx_latched_status_seven & $past(s.rx_latched_status_seven)) == $past(s.rx_latched_status_seven))
    else $error("writing zero cleared a latched flag");

  a_tx_empty: assert property (
    s.txst == TX_SEND && src_buf && TX_DL_REQ &&
    s.txcnt == tx_len - 4'h1 |=> s.tx_latched_status_two && s.txcnt == 4'h0)
    else $error("empty flag missing after last buffer bit");

  a_tx_lsb: assert property (
    s.txst == TX_SEND && src_buf && TX_DL_REQ
    |=> TX_DL_BIT == $past(s.txsh[0]))
    else $error("transmit bit not taken from buffer bottom");

  a_rx_full: assert property (
    esf && RX_DL_STB && s.rxcnt == 4'h7
    |=> s.rx_latched_status_seven[B_RXFULL] && s.rxdl == $past({RX_DL_BIT, s.rxsh[7:1]}))
    else $error("receive buffer full not flagged");

  a_e1_af: assert property (
    !T1_MODE && E1_AF_STB
    |=> s.rx_latched_status_two[B_AF] && s.raf == $past(E1_AF_IN))
    else $error("align frame not captured");

  a_e1_mf: assert property (
    !T1_MODE && E1_MF_STB
    |=> s.rx_latched_status_two[B_MF] && s.e1mf == $past(E1_MF_IN))
    else $error("multiframe bytes not captured");

  a_rd_idle: assert property (!(RD && hit) |=> RD_DATA == 8'h00)
    else $error("read data outside read answer cycle");
endmodule : dlo_top
`default_nettype wire

// ==== pkg/dlo_pkg.sv ====
// Shared constants and types for the data-link overhead access block
package dlo_pkg;
  localparam int DW = 8;
  localparam int AW = 12;
  localparam int LW = 9;
  // Local register offsets inside one framer window
  localparam logic [8:0] OFF_BOC_CTL = 9'h015;
  localparam logic [8:0] OFF_RX_DL   = 9'h062;
  localparam logic [8:0] OFF_CODE    = 9'h063;
  localparam logic [8:0] OFF_RAF     = 9'h064;
  localparam logic [8:0] OFF_RNAF    = 9'h065;
  localparam logic [8:0] OFF_SI_AF   = 9'h066;
  localparam logic [8:0] OFF_SI_NAF  = 9'h067;
  localparam logic [8:0] OFF_SA4     = 9'h069;
  localparam logic [8:0] OFF_SA5     = 9'h06A;
  localparam logic [8:0] OFF_SA6     = 9'h06B;
  localparam logic [8:0] OFF_SA7     = 9'h06C;
  localparam logic [8:0] OFF_SA8     = 9'h06D;
  localparam logic [8:0] OFF_RX_LATCHED_STATUS_TWO    = 9'h091;
  localparam logic [8:0] OFF_RX_LATCHED_STATUS_SEVEN    = 9'h096;
  localparam logic [8:0] OFF_RIM2    = 9'h0A1;
  localparam logic [8:0] OFF_RX_INTERRUPT_MASK_SEVEN    = 9'h0A6;
  localparam logic [8:0] OFF_TSA_CTL = 9'h114;
  localparam logic [8:0] OFF_TX_DL   = 9'h162;
  localparam logic [8:0] OFF_TAF     = 9'h164;
  localparam logic [8:0] OFF_TNAF    = 9'h165;
  localparam logic [8:0] OFF_TSI_AF  = 9'h166;
  localparam logic [8:0] OFF_TSI_NAF = 9'h167;
  localparam logic [8:0] OFF_TSA4    = 9'h169;
  localparam logic [8:0] OFF_TSA5    = 9'h16A;
  localparam logic [8:0] OFF_TSA6    = 9'h16B;
  localparam logic [8:0] OFF_TSA7    = 9'h16C;
  localparam logic [8:0] OFF_TSA8    = 9'h16D;
  localparam logic [8:0] OFF_TCR2    = 9'h182;
  localparam logic [8:0] OFF_TX_LATCHED_STATUS_TWO    = 9'h191;
  localparam logic [8:0] OFF_TX_INTERRUPT_MASK_TWO    = 9'h1A1;
  // Field positions
  localparam int B_DET     = 0;
  localparam int B_CLR     = 1;
  localparam int B_RXFULL  = 2;
  localparam int B_AF      = 0;
  localparam int B_MF      = 1;
  localparam int B_TXEMPTY = 4;
  localparam int B_SRC     = 7;
  localparam int FILT_LSB  = 0;
  localparam int DIS_LSB   = 2;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_CNT = 4'h0;
  // Bit counts per buffer pass, code framing, filter and disintegration repetition counts
  localparam logic [3:0] DL_BITS_ESF = 4'h8;
  localparam logic [3:0] DL_BITS_D4  = 4'h6;
  localparam logic [7:0] BOC_FLAG    = 8'hFF;
  localparam logic [3:0] FILT_REP [4] = '{4'h1, 4'h3, 4'h5, 4'h7};
  localparam logic [3:0] DIS_REP  [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } dlo_tx_st_t;
endpackage : dlo_pkg

// ==== pkg/dlo_boc_if.sv ====
// Link between the register core and the bit-oriented code detector
`timescale 1ns/1ps
`default_nettype none
interface dlo_boc_if;
  logic       en;
  logic       stb;
  logic       dbit;
  logic [1:0] filt;
  logic [1:0] dis;
  logic [5:0] code;
  logic       det;
  logic       clr;
  modport core (output en, stb, dbit, filt, dis, input code, det, clr);
  modport boc  (input en, stb, dbit, filt, dis, output code, det, clr);
endinterface : dlo_boc_if
`default_nettype wire

// ==== hdl/dlo_boc.sv ====
// Receive bit-oriented code detector with filter and disintegration
`timescale 1ns/1ps
`default_nettype none
module dlo_boc (
  input wire logic clk,
  input wire logic nrst,
  dlo_boc_if.boc   b
);
  import dlo_pkg::*;

  typedef struct packed {
    logic [15:0] sr;
    logic [5:0]  cand;
    logic [3:0]  rep;
    logic [5:0]  rcode;
    logic        active;
    logic [8:0]  miss;
    logic        det;
    logic        clr;
  } dlo_boc_st_t;

  dlo_boc_st_t s;
  dlo_boc_st_t next_s;

  // Pattern 0xxxxxx0 followed by eight ones, newest bit at sr[0]
  function automatic logic boc_match(input logic [15:0] v);
    boc_match = (v[7:0] == BOC_FLAG) && !v[8] && !v[15];
  endfunction : boc_match

  assign b.code = s.rcode;
  assign b.det  = s.det;
  assign b.clr  = s.clr;

  // Detector state update, idle outside T1 ESF
  always_comb begin
    next_s     = s;
    next_s.det = 1'b0;
    next_s.clr = 1'b0;
    if (!b.en) begin
      next_s = '0;
    end else if (b.stb) begin
      next_s.sr = {s.sr[14:0], b.dbit};
      if (boc_match(next_s.sr)) begin
        next_s.miss = 9'h000;
        if (next_s.sr[14:9] == s.cand && s.rep != 4'h0) begin
          next_s.rep = (s.rep == 4'hF) ? s.rep : s.rep + 4'h1;
        end else begin
          next_s.cand = next_s.sr[14:9];
          next_s.rep  = 4'h1;
        end
        // Same code while active stays silent after a host clear
        if (next_s.rep >= FILT_REP[b.filt] &&
            (!s.active || next_s.cand != s.rcode)) begin
          next_s.det    = 1'b1;
          next_s.rcode  = next_s.cand;
          next_s.active = 1'b1;
        end
      end else begin
        next_s.miss = (s.miss == 9'h1FF) ? s.miss : s.miss + 9'h001;
        if (s.active && next_s.miss >= {1'b0, DIS_REP[b.dis], 4'h0}) begin
          next_s.clr    = 1'b1;
          next_s.active = 1'b0;
          next_s.rep    = 4'h0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_boc_off: assert property (!b.en |=> !b.det && !b.clr)
    else $error("code event outside T1 ESF");
  a_det_code: assert property (b.det |-> s.active && b.code == s.cand)
    else $error("reported code differs from candidate");
  a_clr_only: assert property (b.clr |-> !s.active && $past(s.active))
    else $error("clear without an active code");
endmodule : dlo_boc
`default_nettype wire

// ==== sim/dlo_far.sv ====
// Far-end framer model: data-link bits in, transmit bit pulls out
`timescale 1ns/1ps
`default_nettype none
module dlo_far (
  input  wire logic clk,
  output logic      rx_stb,
  output logic      rx_bit,
  output logic      mf_stb,
  output logic      tx_req,
  input  wire logic tx_bit
);
  // Quiet line at time zero
  initial begin
    rx_stb = 1'b0;
    rx_bit = 1'b1;
    mf_stb = 1'b0;
    tx_req = 1'b0;
  end
  // Bits leave LSB first; between strobes the line shows the inverse of
  // the last bit, so a sample taken off the strobe cannot pass by luck
  task automatic send(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_stb <= 1'b1;
      rx_bit <= w[i];
      @(posedge clk);
      rx_stb <= 1'b0;
      rx_bit <= ~w[i];
    end
  endtask : send
  // One D4 multiframe boundary pulse
  task automatic boundary();
    @(posedge clk);
    mf_stb <= 1'b1;
    @(posedge clk);
    mf_stb <= 1'b0;
  endtask : boundary
  // One request per bit; the bit stands from the cycle after the request
  task automatic pull(input int n, output logic [7:0] v);
    v = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      tx_req <= 1'b1;
      @(posedge clk);
      tx_req <= 1'b0;
      #1 v[i] = tx_bit;
    end
  endtask : pull
endmodule : dlo_far
`default_nettype wire

// ==== sim/dlo_top_bench.sv ====
// Self-checking bench for the data-link overhead access block
`timescale 1ns/1ps
`default_nettype none
module dlo_top_bench;
  import dlo_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [11:0] MF_OFF [7] = '{12'h066, 12'h067, 12'h069,
    12'h06A, 12'h06B, 12'h06C, 12'h06D};
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wdata, rdata, v, af_in, naf_in;
  logic [7*DW-1:0] mf_in;
  logic clk, nrst, wr, rd, int_n, t1, esf, af_stb, e1mf;
  logic rx_stb, rx_bit, mf_stb, tx_req, tx_bit, tx_en;
  int   fail_count = 0;
  int   checks_done = 0;
  int   cyc = 0;

  dlo_top #(.FRAMER(1)) u_dut (
    .CLK(clk), .NRST(nrst), .ADDR(addr), .WR_DATA(wdata), .WR(wr),
    .RD(rd), .RD_DATA(rdata), .INT_N(int_n), .T1_MODE(t1),
    .ESF_MODE(esf), .RX_DL_STB(rx_stb), .RX_DL_BIT(rx_bit),
    .RX_MF_STB(mf_stb), .TX_DL_REQ(tx_req), .TX_DL_BIT(tx_bit),
    .TX_DL_EN(tx_en), .E1_AF_STB(af_stb), .E1_AF_IN(af_in),
    .E1_NAF_IN(naf_in), .E1_MF_STB(e1mf), .E1_MF_IN(mf_in));

  dlo_far u_far (.clk(clk), .rx_stb(rx_stb), .rx_bit(rx_bit),
    .mf_stb(mf_stb), .tx_req(tx_req), .tx_bit(tx_bit));

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic conclude();
    $display("checks_done %0d fail_count %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask : chk1
  // Bus cycles: one-cycle strobes, read data only in the following cycle
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  task automatic rchk(input logic [11:0] a, input logic [7:0] e,
                      input string n);
    logic [7:0] d;
    rreg(a, d);
    chk8(n, e, d);
  endtask : rchk
  // Wait n edges, then step off the last edge so that outputs have settled
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // Main sequence
  initial begin
    nrst = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    t1 = 1'b1;
    esf = 1'b1;
    af_stb = 1'b0;
    e1mf = 1'b0;
    af_in = '0;
    naf_in = '0;
    mf_in = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    chk1("int_n", 1'b1, int_n);
    rchk(12'h096, 8'h00, "rx_latched_status_seven");
    rchk(12'h191, 8'h00, "tx_latched_status_two");
    // Plain register, foreign framer window, unmapped and read-only places
    wreg(12'h114, 8'h3C);
    wreg(12'h314, 8'h99);
    rchk(12'h114, 8'h3C, "tx spare control");
    rchk(12'h314, 8'h00, "foreign window");
    rchk(12'h0FF, 8'h00, "unmapped");
    wreg(12'h063, 8'hFF);
    rchk(12'h063, 8'h00, "code value");
    // ESF receive byte, full flag, interrupt and write-one clear
    wreg(12'h0A6, 8'h04);
    u_far.send(16'h00A5, 16'd8);
    idle(3);
    rchk(12'h062, 8'hA5, "rx buffer");
    rchk(12'h096, 8'h04, "rx_latched_status_seven");
    chk1("int_n", 1'b0, int_n);
    wreg(12'h096, 8'h00);
    idle(2);
    chk1("int_n", 1'b0, int_n);
    wreg(12'h096, 8'h04);
    idle(2);
    chk1("int_n", 1'b1, int_n);
    rchk(12'h096, 8'h00, "rx_latched_status_seven");
    // Code 0B framed as 0 d0..d5 0 then eight ones, first data bit is MSB
    wreg(12'h015, 8'h00);
    wreg(12'h0A6, 8'h03);
    u_far.send(16'hFF68, 16);
    u_far.send(16'hFF68, 16);
    idle(4);
    rchk(12'h063, 8'h0B, "code value");
    rreg(12'h096, v);
    chk1("detect flag", 1'b1, v[0]);
    chk1("int_n", 1'b0, int_n);
    wreg(12'h096, 8'hFF);
    u_far.send(16'hFF68, 16);
    idle(4);
    rreg(12'h096, v);
    chk1("detect flag", 1'b0, v[0]);
    u_far.send(16'h0000, 16);
    u_far.send(16'h0000, 16);
    idle(4);
    rreg(12'h096, v);
    chk1("clear flag", 1'b1, v[1]);
    chk1("int_n", 1'b0, int_n);
    // Filter of three repetitions: two are not enough, the third is
    wreg(12'h096, 8'hFF);
    wreg(12'h015, 8'h01);
    u_far.send(16'hFF68, 16);
    u_far.send(16'hFF68, 16);
    idle(4);
    rreg(12'h096, v);
    chk1("detect flag", 1'b0, v[0]);
    u_far.send(16'hFF68, 16);
    idle(4);
    rreg(12'h096, v);
    chk1("detect flag", 1'b1, v[0]);
    wreg(12'h0A6, 8'h00);
    wreg(12'h096, 8'hFF);
    // Transmit buffer: source select, LSB first, no stuffing, resend
    wreg(12'h1A1, 8'h10);
    wreg(12'h182, 8'h80);
    wreg(12'h162, 8'hFE);
    idle(2);
    chk1("tx_dl_en", 1'b0, tx_en);
    wreg(12'h182, 8'h00);
    idle(2);
    chk1("tx_dl_en", 1'b1, tx_en);
    u_far.pull(8, v);
    chk8("tx bits", 8'hFE, v);
    idle(2);
    rchk(12'h191, 8'h10, "tx_latched_status_two");
    chk1("int_n", 1'b0, int_n);
    wreg(12'h191, 8'h10);
    idle(2);
    chk1("int_n", 1'b1, int_n);
    u_far.pull(8, v);
    chk8("tx resend", 8'hFE, v);
    // D4 Fs pattern from the low six bits only
    wreg(12'h182, 8'h80);
    esf <= 1'b0;
    wreg(12'h162, 8'hDC);
    wreg(12'h182, 8'h00);
    idle(2);
    u_far.pull(6, v);
    chk8("fs bits", 8'h1C, v);
    wreg(12'h191, 8'h10);
    // D4 receive waits for the multiframe boundary
    wreg(12'h096, 8'hFF);
    u_far.send(16'h002D, 6);
    idle(3);
    rreg(12'h096, v);
    chk1("rx full flag", 1'b0, v[2]);
    u_far.boundary();
    idle(3);
    rchk(12'h062, 8'h2D, "rx buffer");
    rreg(12'h096, v);
    chk1("rx full flag", 1'b1, v[2]);
    rchk(12'h063, 8'h00, "code value");
    // E1 align frame and multiframe capture
    t1 <= 1'b0;
    af_in <= 8'h9B;
    naf_in <= 8'h4E;
    mf_in <= 56'h77665544332211;
    wreg(12'h0A1, 8'h03);
    @(posedge clk);
    af_stb <= 1'b1;
    @(posedge clk);
    af_stb <= 1'b0;
    idle(2);
    chk1("int_n", 1'b0, int_n);
    rchk(12'h064, 8'h9B, "align frame");
    rchk(12'h065, 8'h4E, "nonalign frame");
    rchk(12'h091, 8'h01, "rx_latched_status_two");
    wreg(12'h091, 8'h01);
    @(posedge clk);
    e1mf <= 1'b1;
    @(posedge clk);
    e1mf <= 1'b0;
    idle(2);
    rchk(12'h091, 8'h02, "rx_latched_status_two");
    for (int k = 0; k < 7; k++) begin
      rchk(MF_OFF[k], mf_in[8*k +: 8], "multiframe byte");
    end
    conclude();
  end
endmodule : dlo_top_bench
`default_nettype wire
